/* File: inc/ilcmg_pkg.sv */
/*
 * constants for the second lane-alignment multiframe generator:
 * control characters, fixed link fields, register map and states.
 * assumes one lane per converter, two lanes, two octets per frame.
 */
`default_nettype none
package ilcmg_pkg;
  // ------------------------------------------------------------
  // control characters (sent with the k flag)
  // ------------------------------------------------------------
  localparam logic [7:0] K28_0 = 8'h1c; // start of subsequence
  localparam logic [7:0] K28_3 = 8'h7c; // lane alignment
  localparam logic [7:0] K28_4 = 8'h9c; // start of link config

  // ------------------------------------------------------------
  // fixed link fields, already minus-one where the link wants it
  // ------------------------------------------------------------
  localparam logic [7:0] F_M1   = 8'h01; // two octets per frame
  localparam logic [7:0] M_M1   = 8'h01; // two converters
  localparam logic [1:0] CS_V   = 2'h1;  // one control bit
  localparam logic [4:0] N_M1   = 5'h0d; // 14-bit resolution
  localparam logic [2:0] SUBV   = 3'h0;  // subclass version
  localparam logic [4:0] NP_M1  = 5'h0f; // 16 bits per sample
  localparam logic [2:0] JESDV  = 3'h1;  // link version
  localparam logic [4:0] S_M1   = 5'h00; // one sample per frame
  localparam logic       HD_V   = 1'b0;  // no high density
  localparam logic [4:0] CF_V   = 5'h00; // no control words
  localparam logic [7:0] RSV_V  = 8'h00; // reserved octets
  localparam logic [7:0] CS_N_OCT = {CS_V, 1'b0, N_M1};
  localparam logic [7:0] NP_OCT   = {SUBV, NP_M1};
  localparam logic [7:0] JV_S_OCT = {JESDV, S_M1};
  localparam logic [7:0] HD_CF_OCT = {HD_V, 2'b00, CF_V};

  // ------------------------------------------------------------
  // multiframe layout (octet positions inside the multiframe)
  // ------------------------------------------------------------
  localparam logic [5:0] P_KSTART = 6'h00;
  localparam logic [5:0] P_KCFG   = 6'h01;
  localparam logic [5:0] P_DID    = 6'h02;
  localparam logic [5:0] P_ADJ    = 6'h03;
  localparam logic [5:0] P_LANE   = 6'h04;
  localparam logic [5:0] P_SCRL   = 6'h05;
  localparam logic [5:0] P_FM1    = 6'h06;
  localparam logic [5:0] P_KM1    = 6'h07;
  localparam logic [5:0] P_MM1    = 6'h08;
  localparam logic [5:0] P_CSN    = 6'h09;
  localparam logic [5:0] P_NP     = 6'h0a;
  localparam logic [5:0] P_JVS    = 6'h0b;
  localparam logic [5:0] P_HDCF   = 6'h0c;
  localparam logic [5:0] P_RSV0   = 6'h0d;
  localparam logic [5:0] P_RSV1   = 6'h0e;
  localparam logic [5:0] P_FCHK   = 6'h0f;
  localparam logic [4:0] K_MIN_M1 = 5'h08; // shortest legal K is 9
  localparam logic [7:0] K32_M1   = 8'h1f; // lane octet writable

  // ------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] A_LINK   = 4'h0;
  localparam logic [3:0] A_FRAME  = 4'h4;
  localparam logic [3:0] A_STATUS = 4'h8;
  localparam logic [7:0] RST_DID  = 8'h00;
  localparam logic [7:0] RST_ADJ  = 8'h00;
  localparam logic [7:0] RST_LANE = 8'h00;
  localparam logic [7:0] RST_SCRL = 8'h01; // two lanes, no scramble
  localparam logic [7:0] RST_KM1  = 8'h08; // nine frames
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MF1  = 2'b01,
    ST_MF2  = 2'b10,
    ST_DONE = 2'b11
  } ilcmg_state_t;
endpackage
`default_nettype wire

/* File: rtl/ilcmg_axil.sv */
/*
 * axi4-lite register slave for the config multiframe generator.
 * assumes a single clock; the clock enable freezes the bus too.
 */
`timescale 1ns/1ns
`default_nettype none
module ilcmg_axil
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] status,
  output logic [31:0]      link_reg,
  output logic [7:0]       km1_reg
);
  logic        aw_held_reg;
  logic [3:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [1:0]  bresp_reg;
  logic        bvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        rvalid_reg;

  // handshakes and decode
  wire do_wr   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_link = aw_addr_reg == ilcmg_pkg::A_LINK;
  wire wr_frm  = aw_addr_reg == ilcmg_pkg::A_FRAME;
  wire rd_take = s_axi_arvalid && !rvalid_reg;
  wire rd_ok   = s_axi_araddr == ilcmg_pkg::A_LINK ||
                 s_axi_araddr == ilcmg_pkg::A_FRAME ||
                 s_axi_araddr == ilcmg_pkg::A_STATUS;
  wire [31:0] rd_mux =
    s_axi_araddr == ilcmg_pkg::A_LINK  ? link_reg :
    s_axi_araddr == ilcmg_pkg::A_FRAME ? {24'h000000, km1_reg} :
    s_axi_araddr == ilcmg_pkg::A_STATUS ? status : 32'h00000000;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // write channel capture and response
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= ilcmg_pkg::RESP_OK;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_link || wr_frm) ? ilcmg_pkg::RESP_OK
                                           : ilcmg_pkg::RESP_ERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // register storage with byte strobes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_reg <= {ilcmg_pkg::RST_SCRL, ilcmg_pkg::RST_LANE,
                   ilcmg_pkg::RST_ADJ, ilcmg_pkg::RST_DID};
      km1_reg  <= ilcmg_pkg::RST_KM1;
    end
    else if (ce && do_wr)
    begin
      for (int b = 0; b < 4; b++)
        if (wr_link && w_strb_reg[b])
          link_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
      if (wr_frm && w_strb_reg[0])
        km1_reg <= w_data_reg[7:0];
    end
  end

  // read channel
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= ilcmg_pkg::RESP_OK;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_ok ? ilcmg_pkg::RESP_OK : ilcmg_pkg::RESP_ERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end
endmodule // ilcmg_axil
`default_nettype wire

/* File: rtl/ilcmg_gen.sv */
/*
 * generator of the second lane-alignment multiframe (link config).
 * assumes cgs_done pulses once when code-group sync ends and that
 * the octet stream is 8b/10b coded downstream.
 */
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - multiframe opens with K28.0, then K28.4 before any config octet
// - config octets go out in the fixed link-config order
// - counts like L, F, K, M, N, N', S are sent minus one
// - device id, adjust/bank, scramble/lanes, K octets are writable
// - checksum is field sum mod 256, sent after the reserved octets
// - K=9 sends 08, checksum 29, counter 22, then K28.3
// - K=32 sends 1F, checksum 40, counters 50 to 7E, then K28.3
// - fixed octets 01, 01, 4D, 0F, 20 for this format
// - resolution 14 bits in 16 bits per sample, minus one coded
// - one sample per frame, sent as zero
// - high density, control words and reserved octets are zero
// - two lanes advertised as 01, scramble bit zero by default
// - other octets come from an 8-bit counter reset by sync end
// - the alignment sequence is never scrambled
module ilcmg_gen
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        cgs_done,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       oct_data,
  output logic             oct_is_k,
  output logic             oct_valid,
  output logic [5:0]       oct_pos,
  output logic             ilas_busy,
  output logic             scramble_en
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // fixed fields folded into the sum, declared ahead of their use
  localparam logic [7:0] F_FIX = ilcmg_pkg::F_M1;
  localparam logic [7:0] M_M1  = ilcmg_pkg::M_M1;

  // field sum of all link-config fields, modulo 256
  function automatic logic [7:0] field_sum(
    input logic [7:0] did, input logic [7:0] adj,
    input logic [7:0] lane, input logic [7:0] scrl,
    input logic [7:0] km1);
    logic [7:0] s;
    s = did + {4'h0, adj[7:4]} + {4'h0, adj[3:0]};
    s = s + {7'h00, lane[6]} + {7'h00, lane[5]} + {3'h0, lane[4:0]};
    s = s + {7'h00, scrl[7]} + {3'h0, scrl[4:0]} + F_FIX + {3'h0, km1[4:0]};
    s = s + M_M1 + {6'h00, ilcmg_pkg::CS_V} + {3'h0, ilcmg_pkg::N_M1};
    s = s + {5'h00, ilcmg_pkg::SUBV} + {3'h0, ilcmg_pkg::NP_M1};
    s = s + {5'h00, ilcmg_pkg::JESDV} + {3'h0, ilcmg_pkg::S_M1};
    s = s + {7'h00, ilcmg_pkg::HD_V} + {3'h0, ilcmg_pkg::CF_V};
    return s;
  endfunction

  // last octet position of a multiframe: 2*(K-1)+1
  function automatic logic [5:0] last_pos(input logic [4:0] km1);
    return {km1, 1'b1};
  endfunction

  // ------------------------------------------------------------
  // registers and their snapshot
  // ------------------------------------------------------------
  logic [31:0]             link_reg;
  logic [7:0]              km1_reg;
  logic [31:0]             status;
  logic [7:0]              did_snap_reg;
  logic [7:0]              adj_snap_reg;
  logic [7:0]              lane_snap_reg;
  logic [7:0]              scrl_snap_reg;
  logic [7:0]              km1_snap_reg;
  logic [7:0]              fchk_snap_reg;
  ilcmg_pkg::ilcmg_state_t st_reg;
  ilcmg_pkg::ilcmg_state_t st_next;
  logic [5:0]              pos_reg;
  logic [5:0]              pos_next;
  logic [7:0]              lane_cnt_reg;
  logic [7:0]              data_reg;
  logic                    is_k_reg;
  logic                    valid_reg;
  logic [5:0]              opos_reg;

  ilcmg_axil u_regs
  (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status        (status),
    .link_reg      (link_reg),
    .km1_reg       (km1_reg)
  );

  // ------------------------------------------------------------
  // live field views
  // ------------------------------------------------------------
  // lane octet is writable only in the 32-frame case; k clamped to 9
  wire [7:0] lane_live = (km1_reg == ilcmg_pkg::K32_M1) ?
                         link_reg[23:16] : 8'h00;
  wire [7:0] km1_live  = (km1_reg[4:0] < ilcmg_pkg::K_MIN_M1) ?
                         {3'h0, ilcmg_pkg::K_MIN_M1} :
                         {3'h0, km1_reg[4:0]};
  wire [7:0] fchk_live = field_sum(link_reg[7:0], link_reg[15:8],
                         lane_live, link_reg[31:24], km1_live);
  assign status = {14'h0000, st_reg, fchk_snap_reg, lane_cnt_reg};

  // ------------------------------------------------------------
  // sequence control
  // ------------------------------------------------------------
  wire mf_end = pos_reg == last_pos(km1_snap_reg[4:0]);
  always_comb
  begin
    st_next  = st_reg;
    pos_next = pos_reg + 6'h01;
    case (st_reg)
      ilcmg_pkg::ST_IDLE:
        pos_next = 6'h00;
      ilcmg_pkg::ST_MF1:
        if (mf_end)
        begin
          st_next  = ilcmg_pkg::ST_MF2;
          pos_next = 6'h00;
        end
      ilcmg_pkg::ST_MF2:
        if (mf_end)
        begin
          st_next  = ilcmg_pkg::ST_DONE;
          pos_next = 6'h00;
        end
      ilcmg_pkg::ST_DONE:
        pos_next = 6'h00;
      default:
      begin
        st_next  = ilcmg_pkg::ST_IDLE;
        pos_next = 6'h00;
      end
    endcase
  end

  // state, position and alignment counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= ilcmg_pkg::ST_IDLE;
      pos_reg      <= 6'h00;
      lane_cnt_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (cgs_done)
      begin
        st_reg       <= ilcmg_pkg::ST_MF1;
        pos_reg      <= 6'h00;
        lane_cnt_reg <= 8'h00;
      end
      else
      begin
        st_reg       <= st_next;
        pos_reg      <= pos_next;
        lane_cnt_reg <= lane_cnt_reg + 8'h01;
      end
    end
  end

  // snapshot of the fields at each sequence start
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      did_snap_reg  <= ilcmg_pkg::RST_DID;
      adj_snap_reg  <= ilcmg_pkg::RST_ADJ;
      lane_snap_reg <= ilcmg_pkg::RST_LANE;
      scrl_snap_reg <= ilcmg_pkg::RST_SCRL;
      km1_snap_reg  <= ilcmg_pkg::RST_KM1;
      fchk_snap_reg <= 8'h00;
    end
    else if (ce && cgs_done)
    begin
      did_snap_reg  <= link_reg[7:0];
      adj_snap_reg  <= link_reg[15:8];
      lane_snap_reg <= lane_live;
      scrl_snap_reg <= link_reg[31:24];
      km1_snap_reg  <= km1_live;
      fchk_snap_reg <= fchk_live;
    end
  end

  // ------------------------------------------------------------
  // octet selection
  // ------------------------------------------------------------
  wire [7:0] cfg_oct =
    pos_reg == ilcmg_pkg::P_DID  ? did_snap_reg :
    pos_reg == ilcmg_pkg::P_ADJ  ? adj_snap_reg :
    pos_reg == ilcmg_pkg::P_LANE ? lane_snap_reg :
    pos_reg == ilcmg_pkg::P_SCRL ? scrl_snap_reg :
    pos_reg == ilcmg_pkg::P_FM1  ? ilcmg_pkg::F_M1 :
    pos_reg == ilcmg_pkg::P_KM1  ? km1_snap_reg :
    pos_reg == ilcmg_pkg::P_MM1  ? ilcmg_pkg::M_M1 :
    pos_reg == ilcmg_pkg::P_CSN  ? ilcmg_pkg::CS_N_OCT :
    pos_reg == ilcmg_pkg::P_NP   ? ilcmg_pkg::NP_OCT :
    pos_reg == ilcmg_pkg::P_JVS  ? ilcmg_pkg::JV_S_OCT :
    pos_reg == ilcmg_pkg::P_HDCF ? ilcmg_pkg::HD_CF_OCT :
    pos_reg == ilcmg_pkg::P_FCHK ? fchk_snap_reg :
    ilcmg_pkg::RSV_V;
  wire in_mf2  = st_reg == ilcmg_pkg::ST_MF2 && !cgs_done;
  wire is_cfg  = pos_reg >= ilcmg_pkg::P_DID &&
                 pos_reg <= ilcmg_pkg::P_FCHK;
  wire is_kch  = pos_reg == ilcmg_pkg::P_KSTART ||
                 pos_reg == ilcmg_pkg::P_KCFG || mf_end;
  wire [7:0] kch = pos_reg == ilcmg_pkg::P_KSTART ? ilcmg_pkg::K28_0 :
                   pos_reg == ilcmg_pkg::P_KCFG   ? ilcmg_pkg::K28_4 :
                   ilcmg_pkg::K28_3;
  wire [7:0] oct_next = is_kch ? kch :
                        is_cfg ? cfg_oct : lane_cnt_reg;

  // registered octet output
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_reg  <= 8'h00;
      is_k_reg  <= 1'b0;
      valid_reg <= 1'b0;
      opos_reg  <= 6'h00;
    end
    else if (ce)
    begin
      data_reg  <= in_mf2 ? oct_next : 8'h00;
      is_k_reg  <= in_mf2 && is_kch;
      valid_reg <= in_mf2;
      opos_reg  <= pos_reg;
    end
  end

  assign oct_data    = data_reg;
  assign oct_is_k    = is_k_reg;
  assign oct_valid   = valid_reg;
  assign oct_pos     = opos_reg;
  assign ilas_busy   = st_reg == ilcmg_pkg::ST_MF1 ||
                       st_reg == ilcmg_pkg::ST_MF2;
  // scrambling held off for the whole alignment sequence, including
  // the closing octet that still stands one cycle after the state ends
  assign scramble_en = link_reg[31] && !ilas_busy && !oct_valid &&
                       st_reg == ilcmg_pkg::ST_DONE;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  wire [5:0] last_o = last_pos(km1_snap_reg[4:0]);
  sequence s_enter;
    ce && !cgs_done && st_reg == ilcmg_pkg::ST_MF1 && mf_end;
  endsequence
  sequence s_first;
    oct_valid && oct_is_k && oct_data == ilcmg_pkg::K28_0;
  endsequence

  start_k_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_enter ##1 (ce && !cgs_done) |=> s_first)
    else $error("multiframe did not open with start character");
  cfg_k_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == ilcmg_pkg::P_KCFG |->
    oct_is_k && oct_data == ilcmg_pkg::K28_4)
    else $error("config start character missing");
  cfg_order_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == ilcmg_pkg::P_DID |->
    !oct_is_k && oct_data == did_snap_reg)
    else $error("device id octet out of place");
  fchk_val_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == ilcmg_pkg::P_FCHK |->
    oct_data == field_sum(did_snap_reg, adj_snap_reg, lane_snap_reg,
                          scrl_snap_reg, km1_snap_reg))
    else $error("checksum octet wrong");
  fixed_oct_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == ilcmg_pkg::P_CSN |->
    oct_data == ilcmg_pkg::CS_N_OCT && $past(oct_data) == ilcmg_pkg::M_M1)
    else $error("fixed format octets wrong");
  zero_oct_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == ilcmg_pkg::P_RSV1 |->
    oct_data == ilcmg_pkg::RSV_V && !oct_is_k)
    else $error("reserved octet not zero");
  km1_oct_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == ilcmg_pkg::P_KM1 |->
    oct_data[4:0] == km1_snap_reg[4:0] && last_o == {oct_data[4:0], 1'b1})
    else $error("frames octet disagrees with length");
  cnt_fill_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos > ilcmg_pkg::P_FCHK && oct_pos != last_o |->
    !oct_is_k && oct_data == lane_cnt_reg - 8'h01)
    else $error("counter octet wrong");
  end_k_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oct_valid && oct_pos == last_o |->
    oct_is_k && oct_data == ilcmg_pkg::K28_3)
    else $error("multiframe not closed by alignment character");
  no_scr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ilas_busy || oct_valid |-> !scramble_en)
    else $error("scrambling during alignment sequence");
  cnt_rst_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && cgs_done |=> lane_cnt_reg == 8'h00 &&
    st_reg == ilcmg_pkg::ST_MF1)
    else $error("sync end did not restart counter");
endmodule // ilcmg_gen
`default_nettype wire

/* File: tb/ilcmg_rx.sv */
/*
 * far-side receiver model: collects second-multiframe octets.
 * assumes the octet stream is sampled at the rising core_clk edge.
 */
`timescale 1ns/1ns
`default_nettype none
module ilcmg_rx
(
  input wire logic       core_clk,
  input wire logic [7:0] oct_data,
  input wire logic       oct_is_k,
  input wire logic       oct_valid,
  input wire logic [5:0] oct_pos,
  input wire logic       scramble_en
);
  logic [8:0] q[$];
  int         scr_hit = 0;
  int         pos_bad = 0;
  // keep each valid octet with its k flag, note stray scrambling
  always @(posedge core_clk)
    if (oct_valid)
    begin
      if (oct_pos != q.size()) pos_bad++;
      if (scramble_en) scr_hit++;
      q.push_back({oct_is_k, oct_data});
    end
endmodule // ilcmg_rx
`default_nettype wire

/* File: tb/ilcmg_gen_tb.sv */
/*
 * bench for ilcmg_gen: axi setup, sync pulses, octet stream checks.
 * assumes ilcmg_rx stands at the far side and collects the octets.
 */
`timescale 1ns/1ns
`default_nettype none
module ilcmg_gen_tb;
  logic        core_clk, rst_n, cgs_done, awvalid, wvalid, bready;
  logic        arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  oct_data, did, adj, lane, scrl, km1, ln;
  logic [5:0]  oct_pos;
  logic        oct_is_k, oct_valid, ilas_busy, scramble_en;
  int          failures = 0, n_tests = 0, cyc = 0, k, seed = 78201;
  ilcmg_gen uut (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .cgs_done(cgs_done), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .oct_data(oct_data), .oct_is_k(oct_is_k),
    .oct_valid(oct_valid), .oct_pos(oct_pos), .ilas_busy(ilas_busy),
    .scramble_en(scramble_en));
  ilcmg_rx rx (.core_clk(core_clk), .oct_data(oct_data),
    .oct_is_k(oct_is_k), .oct_valid(oct_valid), .oct_pos(oct_pos),
    .scramble_en(scramble_en));
  // expected {k, octet} at multiframe position p
  function automatic logic [8:0] ex(int p);
    logic [7:0] c;
    c = did + adj[7:4] + adj[3:0] + ln[6] + ln[5] + ln[4:0] + scrl[7]
      + scrl[4:0] + km1[4:0] + 8'h20;
    case (p)
      0: ex = {1'b1, 8'h1c};
      1: ex = {1'b1, 8'h9c};
      2: ex = {1'b0, did};
      3: ex = {1'b0, adj};
      4: ex = {1'b0, ln};
      5: ex = {1'b0, scrl};
      6, 8: ex = 9'h001;
      7: ex = {4'h0, km1[4:0]};
      9: ex = 9'h04d;
      10: ex = 9'h00f;
      11: ex = 9'h020;
      12, 13, 14: ex = 9'h000;
      15: ex = {1'b0, c};
      default: ex = (p == 2*k-1) ? 9'h17c : {1'b0, 8'(2*k+p)};
    endcase
  endfunction
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_of_test;
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // register bus master: hold each channel until its ready is seen
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever
    begin
      @(posedge core_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 0;
  endtask
  task rdr(input logic [3:0] a);
    @(posedge core_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever
    begin
      @(posedge core_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd = rdata; rs = rresp;
    rready <= 0;
  endtask
  task cfg(input logic [7:0] d, a, l, s, f);
    did = d; adj = a; lane = l; scrl = s; km1 = f; k = f + 1;
    ln = (f == 8'h1f) ? l : 8'h00;
    wr(4'h0, {s, l, a, d}); cmp(rs, 2'h0);
    wr(4'h4, {24'h0, f}); rdr(4'h0); cmp(rd, {s, l, a, d});
  endtask
  task pulse;
    @(posedge core_clk) cgs_done <= 1;
    @(posedge core_clk) cgs_done <= 0;
    #1 rx.q.delete();
  endtask
  // one sync pulse (plus a restart mid-stream when ab is set), then the whole multiframe
  task seq(input bit ab);
    pulse();
    if (ab)
    begin
      while (rx.q.size() < 3) @(posedge core_clk);
      pulse();
    end
    while (rx.q.size() < 2*k) @(posedge core_clk);
    for (int p = 0; p < 2*k; p++) cmp(rx.q[p], ex(p));
  endtask
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (++cyc == 20000)
  begin
    failures++;
    end_of_test;
  end
  initial
  begin
    {rst_n, cgs_done, awvalid, wvalid, bready, arvalid, rready} = 0;
    {awaddr, araddr, wdata} = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    rdr(4'h0); cmp(rd, 32'h01000000);
    rdr(4'h4); cmp(rd, 32'h08);
    rdr(4'hc); cmp(rs, 2'h2); cmp(rd, 0);
    did = 0; adj = 0; scrl = 8'h01; km1 = 8'h08; ln = 0; k = 9;
    seq(0);
    cfg(8'hff, 8'hff, 8'h7f, 8'h81, 8'h1f); seq(1);
    for (int i = 0; i < 6; i++)
    begin
      cfg($random(seed), $random(seed), $random(seed) & 8'h7f,
          ($random(seed) & 8'h80) | 8'h01, i[0] ? 8'h1f : 8'h08);
      seq(0);
    end
    while (ilas_busy) @(posedge core_clk);
    #1 cmp(scramble_en, scrl[7]); cmp(rx.scr_hit, 0);
    cmp(rx.pos_bad, 0);
    end_of_test;
  end
endmodule // ilcmg_gen_tb
`default_nettype wire
